// ==== hdl/checkback_defines.vh ====
`ifndef CHECKBACK_DEFINES_VH
`define CHECKBACK_DEFINES_VH
// ----------------------------------------
// register byte offsets (haddr[7:0])
// ----------------------------------------
`define OFS_CFG 8'h00
`define OFS_OUTSEL 8'h04
`define OFS_HOURS 8'h08
`define OFS_TIMING 8'h0C
`define OFS_RETRY 8'h10
`define OFS_TOD 8'h14
`define OFS_CMD 8'h18
`define OFS_STATUS 8'h1C
// ----------------------------------------
// configuration and command bit positions
// ----------------------------------------
`define CFG_MAJ_POL 0
`define CFG_MIN_POL 1
`define CFG_MOMENT 2
`define CFG_LOWP 3
`define CFG_TIMED 4
`define CFG_RECOV 5
`define CFG_AUTO 6
`define CFG_SYNC 7
`define CFG_UPOL 8
`define CMD_TEST 0
`define CMD_LOOP 1
`define CMD_CLR 2
// ----------------------------------------
// status source codes for the user outputs
// ----------------------------------------
`define SRC_RECOVER 3'h0
`define SRC_DELAY 3'h1
`define SRC_TESTING 3'h2
`define SRC_PASS 3'h3
`define SRC_DISABLED 3'h4
`define SRC_INRECOV 3'h5
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_CFG 11'h040
`define RST_OUTSEL 11'h132
`define RST_HOURS 32'h0303_0303
`define RST_TIMING 32'h010F_0504
`define RST_RETRY 5'h03
// ----------------------------------------
// limits and timing
// ----------------------------------------
`define RETRY_MAX 5'h14
`define LOOP_MIN 8'h04
`define LOOP_MAX 8'h3C
`define WIN_MIN 5'h01
`define WIN_MAX 5'h18
`define HOUR_MAX 5'h17
`define REC_NEED 2'h3
`define SYNC_HOUR 5'h00
`define SYNC_MIN 6'h1E
`define MOMENT_SEC 8'h05
`define RECOVER_SEC 8'h01
`define SEC_PER_HOUR 12'hE10
`define TIMEBASE_S 1
`define CLK_HZ 10000000
`endif

// ==== hdl/checkback_alarm_scheduler.v ====
// Overview of operation
// - separate polarity for major and minor relays
// - settings change only in custom switch position
// - three user outputs, independent polarity each
// - each output selects one of six sources
// - recovery success gives one second pulse
// - delayed alarm when recovery window expires
// - initiator shows test in progress throughout
// - pass shown after own test passes
// - disabled source while automatic tests off
// - in-recovery source while recovery active
// - alarms sealed or held five seconds
// - retry count 0..20, default 3, error
// - low-power test precedes full-power test
// - four hour slots, defer while busy
// - periodic interval in hours, zero refused
// - loopback keys carrier 4 to 60 seconds
// - expedited tests, leave after three passes
// - window 1..24 hours then delayed alarm
// - master starts clock sync at 00:30
// - master enters recovery after failed test
// - auto off: manual tests only, no sync
// - interval type selects periodic or timed
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "checkback_defines.vh"

module checkback_alarm_scheduler #(
    parameter TICK_CYCLES = `CLK_HZ * `TIMEBASE_S
)(
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp,
    input wire custom_sel,
    input wire is_master,
    input wire major_event,
    input wire minor_event,
    input wire test_done,
    input wire test_pass,
    input wire msg_fail,
    input wire msg_ok,
    input wire chan_busy,
    input wire panel_test,
    input wire loop_switch,
    output reg major_relay,
    output reg minor_relay,
    output reg [2:0] user_out,
    output reg start_test,
    output reg test_low_power,
    output reg carrier_key,
    output reg sync_start,
    output reg retry_req,
    output reg comm_error
);

// ----------------------------------------
// helpers
// ----------------------------------------
// contact closed when active matches close polarity
function drv;
    input active;
    input pol;
    begin
        drv = ~(active ^ pol);
    end
endfunction

localparam T_IDLE = 2'd0;
localparam T_LOW = 2'd1;
localparam T_FULL = 2'd2;

reg [10:0] cfg_reg;
reg [10:0] outsel_reg;
reg [31:0] hours_reg;
reg [31:0] timing_reg;
reg [4:0] retry_reg;
reg wr_pend_reg;
reg [7:0] wr_addr_reg;
reg refused_reg;
reg [23:0] div_reg;
reg tick_reg;
reg [5:0] sec_reg;
reg [5:0] min_reg;
reg [4:0] hr_reg;
reg [7:0] per_cnt_reg;
reg [7:0] rmin_cnt_reg;
reg due_reg;
reg manual_reg;
reg [1:0] tstate_reg;
reg pass_reg;
reg recov_reg;
reg [1:0] succ_reg;
reg [11:0] rsec_reg;
reg [4:0] rhr_reg;
reg delayed_reg;
reg [7:0] rpulse_reg;
reg maj_act_reg;
reg min_act_reg;
reg [7:0] maj_cnt_reg;
reg [7:0] min_cnt_reg;
reg [7:0] key_cnt_reg;
reg loop_sw_reg;
reg [4:0] fail_cnt_reg;

wire [7:0] period = timing_reg[7:0];
wire [7:0] loop_dur = timing_reg[15:8];
wire [7:0] rec_per = timing_reg[23:16];
wire [4:0] window = timing_reg[28:24];
wire auto_en = cfg_reg[`CFG_AUTO];

// ----------------------------------------
// bus slave
// ----------------------------------------
wire take = hsel & hready & htrans[1];
wire wr_now = wr_pend_reg;
wire cfg_space = (wr_addr_reg != `OFS_TOD) && (wr_addr_reg != `OFS_CMD);
wire cmd_wr = wr_now && (wr_addr_reg == `OFS_CMD);
wire tod_wr = wr_now && (wr_addr_reg == `OFS_TOD);

// range check of written settings
reg wr_ok;
always @*
begin
    case (wr_addr_reg)
    `OFS_OUTSEL:
        wr_ok = (hwdata[2:0] <= `SRC_INRECOV) && (hwdata[6:4] <= `SRC_INRECOV)
            && (hwdata[10:8] <= `SRC_INRECOV);
    `OFS_HOURS:
        wr_ok = (hwdata[4:0] <= `HOUR_MAX) && (hwdata[12:8] <= `HOUR_MAX)
            && (hwdata[20:16] <= `HOUR_MAX) && (hwdata[28:24] <= `HOUR_MAX);
    `OFS_TIMING:
        wr_ok = (hwdata[7:0] != 8'h00) && (hwdata[15:8] >= `LOOP_MIN)
            && (hwdata[15:8] <= `LOOP_MAX) && (hwdata[23:16] != 8'h00)
            && (hwdata[28:24] >= `WIN_MIN) && (hwdata[28:24] <= `WIN_MAX);
    `OFS_RETRY:
        wr_ok = (hwdata[4:0] <= `RETRY_MAX) && (hwdata[31:5] == 27'h0000000);
    `OFS_TOD:
        wr_ok = (hwdata[5:0] < 6'h3C) && (hwdata[13:8] < 6'h3C)
            && (hwdata[20:16] <= `HOUR_MAX);
    default:
        wr_ok = 1'b1;
    endcase
end

wire cfg_wr = wr_now && cfg_space && custom_sel && wr_ok;

// read mux sampled in the address phase
reg [31:0] rd_mux;
always @*
begin
    case (haddr[7:0])
    `OFS_CFG: rd_mux = {21'h000000, cfg_reg};
    `OFS_OUTSEL: rd_mux = {21'h000000, outsel_reg};
    `OFS_HOURS: rd_mux = hours_reg;
    `OFS_TIMING: rd_mux = timing_reg;
    `OFS_RETRY: rd_mux = {27'h0000000, retry_reg};
    `OFS_TOD: rd_mux = {11'h000, hr_reg, 2'h0, min_reg, 2'h0, sec_reg};
    `OFS_STATUS:
        rd_mux = {21'h000000, user_out, refused_reg, carrier_key, min_act_reg,
            maj_act_reg, delayed_reg, recov_reg, pass_reg, tstate_reg != T_IDLE};
    default: rd_mux = 32'h0000_0000;
    endcase
end

// address capture, read data and setting stores
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        hrdata <= 32'h0000_0000;
        hreadyout <= 1'b1;
        hresp <= 1'b0;
        wr_pend_reg <= 1'b0;
        wr_addr_reg <= 8'h00;
        refused_reg <= 1'b0;
        cfg_reg <= `RST_CFG;
        outsel_reg <= `RST_OUTSEL;
        hours_reg <= `RST_HOURS;
        timing_reg <= `RST_TIMING;
        retry_reg <= `RST_RETRY;
    end
    else
    begin
        wr_pend_reg <= take & hwrite;
        wr_addr_reg <= haddr[7:0];
        if (take & ~hwrite)
            hrdata <= rd_mux;
        if (wr_now && (wr_addr_reg != `OFS_CMD) && (wr_addr_reg != `OFS_STATUS))
            refused_reg <= ~(wr_ok && (custom_sel || !cfg_space));
        if (cfg_wr)
        begin
            case (wr_addr_reg)
            `OFS_CFG: cfg_reg <= hwdata[10:0];
            `OFS_OUTSEL: outsel_reg <= {hwdata[10:8], 1'b0, hwdata[6:4], 1'b0, hwdata[2:0]};
            `OFS_HOURS: hours_reg <= hwdata & 32'h1F1F_1F1F;
            `OFS_TIMING: timing_reg <= hwdata & 32'h1FFF_FFFF;
            `OFS_RETRY: retry_reg <= hwdata[4:0];
            default: retry_reg <= retry_reg;
            endcase
        end
    end
end

// ----------------------------------------
// timebase and time of day
// ----------------------------------------
wire min_end = tick_reg && (sec_reg == 6'h3B);
wire hour_end = min_end && (min_reg == 6'h3B);
wire [4:0] next_hr = (hr_reg == `HOUR_MAX) ? 5'h00 : hr_reg + 5'h01;
wire sync_hit = min_end && (hr_reg == `SYNC_HOUR) && (min_reg == `SYNC_MIN - 6'h01);

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        div_reg <= 24'h000000;
        tick_reg <= 1'b0;
        sec_reg <= 6'h00;
        min_reg <= 6'h00;
        hr_reg <= 5'h00;
    end
    else
    begin
        tick_reg <= (div_reg == TICK_CYCLES[23:0] - 24'h000001);
        div_reg <= (div_reg == TICK_CYCLES[23:0] - 24'h000001) ? 24'h000000 : div_reg + 24'h000001;
        if (tod_wr && wr_ok)
        begin
            sec_reg <= hwdata[5:0];
            min_reg <= hwdata[13:8];
            hr_reg <= hwdata[20:16];
        end
        else if (tick_reg)
        begin
            sec_reg <= (sec_reg == 6'h3B) ? 6'h00 : sec_reg + 6'h01;
            if (min_end)
                min_reg <= (min_reg == 6'h3B) ? 6'h00 : min_reg + 6'h01;
            if (hour_end)
                hr_reg <= next_hr;
        end
    end
end

// ----------------------------------------
// schedule
// ----------------------------------------
// one match per hour however many slots agree
wire slot_hit = (hours_reg[4:0] == next_hr) || (hours_reg[12:8] == next_hr)
    || (hours_reg[20:16] == next_hr) || (hours_reg[28:24] == next_hr);
wire per_hit = hour_end && (per_cnt_reg + 8'h01 >= period);
wire rmin_hit = min_end && (rmin_cnt_reg + 8'h01 >= rec_per);
wire sched_hit = recov_reg ? rmin_hit
    : (cfg_reg[`CFG_TIMED] ? (hour_end && slot_hit) : per_hit);
wire test_go = (tstate_reg == T_IDLE) && (manual_reg || (due_reg && !chan_busy));
wire full_done = (tstate_reg == T_FULL) && test_done;
wire rec_exit = full_done && test_pass && recov_reg && (succ_reg == `REC_NEED - 2'h1);

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        per_cnt_reg <= 8'h00;
        rmin_cnt_reg <= 8'h00;
        due_reg <= 1'b0;
        manual_reg <= 1'b0;
        sync_start <= 1'b0;
    end
    else
    begin
        if (hour_end)
            per_cnt_reg <= per_hit ? 8'h00 : per_cnt_reg + 8'h01;
        if (!recov_reg)
            rmin_cnt_reg <= 8'h00;
        else if (min_end)
            rmin_cnt_reg <= rmin_hit ? 8'h00 : rmin_cnt_reg + 8'h01;
        // due waits out a busy channel; set beats clear
        due_reg <= (due_reg && !(test_go && !manual_reg) && auto_en) || (auto_en && sched_hit);
        manual_reg <= (manual_reg && !test_go) || panel_test || (cmd_wr && hwdata[`CMD_TEST]);
        // nightly clock sync from the master
        sync_start <= sync_hit && cfg_reg[`CFG_SYNC] && auto_en && is_master;
    end
end

// ----------------------------------------
// test sequencing and carrier recovery
// ----------------------------------------
always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        tstate_reg <= T_IDLE;
        start_test <= 1'b0;
        test_low_power <= 1'b0;
        pass_reg <= 1'b0;
        recov_reg <= 1'b0;
        succ_reg <= 2'h0;
        rsec_reg <= 12'h000;
        rhr_reg <= 5'h00;
        delayed_reg <= 1'b0;
        rpulse_reg <= 8'h00;
    end
    else
    begin
        start_test <= 1'b0;
        case (tstate_reg)
        T_IDLE:
            if (test_go)
            begin
                start_test <= 1'b1;
                pass_reg <= 1'b0;
                test_low_power <= cfg_reg[`CFG_LOWP];
                tstate_reg <= cfg_reg[`CFG_LOWP] ? T_LOW : T_FULL;
            end
        T_LOW:
            if (test_done)
            begin
                start_test <= 1'b1;
                test_low_power <= 1'b0;
                tstate_reg <= T_FULL;
            end
        T_FULL:
            if (test_done)
            begin
                pass_reg <= test_pass;
                tstate_reg <= T_IDLE;
            end
        default:
            tstate_reg <= T_IDLE;
        endcase
        if (rec_exit)
        begin
            recov_reg <= 1'b0;
            succ_reg <= 2'h0;
        end
        else if (full_done && test_pass && recov_reg)
            succ_reg <= succ_reg + 2'h1;
        else if (full_done && !test_pass)
        begin
            succ_reg <= 2'h0;
            if (!recov_reg && cfg_reg[`CFG_RECOV] && is_master)
            begin
                recov_reg <= 1'b1;
                rsec_reg <= 12'h000;
                rhr_reg <= 5'h00;
            end
        end
        if (recov_reg && tick_reg && (rhr_reg < window))
        begin
            rsec_reg <= (rsec_reg == `SEC_PER_HOUR - 12'h001) ? 12'h000 : rsec_reg + 12'h001;
            if (rsec_reg == `SEC_PER_HOUR - 12'h001)
                rhr_reg <= rhr_reg + 5'h01;
        end
        if (recov_reg && (rhr_reg >= window) && !rec_exit)
            delayed_reg <= 1'b1;
        else if (rec_exit || (cmd_wr && hwdata[`CMD_CLR]))
            delayed_reg <= 1'b0;
        if (rec_exit)
            rpulse_reg <= `RECOVER_SEC + 8'h01;
        else if (tick_reg && (rpulse_reg != 8'h00))
            rpulse_reg <= rpulse_reg - 8'h01;
    end
end

// ----------------------------------------
// alarms, loopback and retries
// ----------------------------------------
wire clr_alarm = cmd_wr && hwdata[`CMD_CLR];
wire moment = cfg_reg[`CFG_MOMENT];
wire loop_go = (cmd_wr && hwdata[`CMD_LOOP]) || (loop_switch && !loop_sw_reg);

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        maj_act_reg <= 1'b0;
        min_act_reg <= 1'b0;
        maj_cnt_reg <= 8'h00;
        min_cnt_reg <= 8'h00;
        key_cnt_reg <= 8'h00;
        loop_sw_reg <= 1'b0;
        carrier_key <= 1'b0;
        fail_cnt_reg <= 5'h00;
        retry_req <= 1'b0;
        comm_error <= 1'b0;
    end
    else
    begin
        if (major_event)
            maj_cnt_reg <= `MOMENT_SEC + 8'h01;
        else if (tick_reg && (maj_cnt_reg != 8'h00))
            maj_cnt_reg <= maj_cnt_reg - 8'h01;
        if (minor_event)
            min_cnt_reg <= `MOMENT_SEC + 8'h01;
        else if (tick_reg && (min_cnt_reg != 8'h00))
            min_cnt_reg <= min_cnt_reg - 8'h01;
        maj_act_reg <= moment ? (major_event || (maj_cnt_reg != 8'h00 && !clr_alarm))
            : (major_event || (maj_act_reg && !clr_alarm));
        min_act_reg <= moment ? (minor_event || (min_cnt_reg != 8'h00 && !clr_alarm))
            : (minor_event || (min_act_reg && !clr_alarm));
        // carrier keyed for the loopback duration
        loop_sw_reg <= loop_switch;
        if (loop_go)
            key_cnt_reg <= loop_dur + 8'h01;
        else if (tick_reg && (key_cnt_reg != 8'h00))
            key_cnt_reg <= key_cnt_reg - 8'h01;
        carrier_key <= loop_go || (key_cnt_reg > 8'h01) || (key_cnt_reg == 8'h01 && !tick_reg);
        // retry until the programmed count, then error
        retry_req <= 1'b0;
        comm_error <= 1'b0;
        if (msg_fail)
        begin
            if (fail_cnt_reg >= retry_reg)
            begin
                comm_error <= 1'b1;
                fail_cnt_reg <= 5'h00;
            end
            else
            begin
                retry_req <= 1'b1;
                fail_cnt_reg <= fail_cnt_reg + 5'h01;
            end
        end
        else if (msg_ok)
            fail_cnt_reg <= 5'h00;
    end
end

// ----------------------------------------
// relay and user output drive
// ----------------------------------------
// source vector
wire [5:0] src = {recov_reg, !auto_en, pass_reg, tstate_reg != T_IDLE,
    delayed_reg, rpulse_reg != 8'h00};

always @(posedge hclk or negedge hresetn)
begin
    if (!hresetn)
    begin
        major_relay <= 1'b1;
        minor_relay <= 1'b1;
        user_out <= 3'h7;
    end
    else
    begin
        major_relay <= drv(maj_act_reg, cfg_reg[`CFG_MAJ_POL]);
        minor_relay <= drv(min_act_reg, cfg_reg[`CFG_MIN_POL]);
        user_out[0] <= drv(src[outsel_reg[2:0]], cfg_reg[`CFG_UPOL]);
        user_out[1] <= drv(src[outsel_reg[6:4]], cfg_reg[`CFG_UPOL + 1]);
        user_out[2] <= drv(src[outsel_reg[10:8]], cfg_reg[`CFG_UPOL + 2]);
    end
end

endmodule // checkback_alarm_scheduler

// ==== test/checkback_partner.sv ====
`timescale 1ns/1ps
// ------------------------------------------
// far-side units answering checkback tests
// ------------------------------------------
module checkback_partner (
    input wire hclk,
    input wire hresetn,
    input wire start_test,
    input wire pass_mode,
    input wire [7:0] lat,
    output logic test_done,
    output logic test_pass
);
    logic busy;
    logic [7:0] cnt;
    // answer after lat cycles; result toggles otherwise
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            busy <= 1'h0;
            cnt <= 8'h00;
            test_done <= 1'h0;
            test_pass <= 1'h0;
        end
        else
        begin
            test_done <= 1'h0;
            test_pass <= ~test_pass;
            if (start_test)
            begin
                busy <= 1'h1;
                cnt <= lat;
            end
            else if (busy && cnt != 8'h00)
                cnt <= cnt - 8'h01;
            else if (busy)
            begin
                busy <= 1'h0;
                test_done <= 1'h1;
                test_pass <= pass_mode;
            end
        end
endmodule // checkback_partner

// ==== test/checkback_alarm_scheduler_checker.sv ====
`timescale 1ns/1ps
// ------------------------------------------
// port checks for the scheduler
// ------------------------------------------
module checkback_alarm_scheduler_checker #(
    parameter TICK_CYCLES = 20
)(
    input wire hclk,
    input wire hresetn,
    input wire hreadyout,
    input wire hresp,
    input wire is_master,
    input wire test_done,
    input wire msg_fail,
    input wire start_test,
    input wire test_low_power,
    input wire carrier_key,
    input wire sync_start,
    input wire retry_req,
    input wire comm_error
);
    logic in_test;
    logic [31:0] key_len;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // open-test flag and length of the current keying
    always @(posedge hclk or negedge hresetn)
        if (!hresetn)
        begin
            in_test <= 1'h0;
            key_len <= 32'h0;
        end
        else
        begin
            in_test <= start_test | (in_test & ~test_done);
            key_len <= carrier_key ? key_len + 32'h1 : 32'h0;
        end
    sequence full_start;
        start_test && !test_low_power;
    endsequence
    AST_BUS_OKAY: assert property (hreadyout && !hresp)
        else $error("bus not okay");
    AST_RETRY_ANSWER: assert property (msg_fail |=> retry_req != comm_error)
        else $error("no retry answer");
    AST_RETRY_CAUSE: assert property ((retry_req || comm_error) |-> $past(msg_fail))
        else $error("retry without failure");
    AST_START_PULSE: assert property (start_test |=> !start_test)
        else $error("start too long");
    AST_ONE_TEST: assert property (start_test |-> !in_test)
        else $error("start while open");
    AST_LOW_FIRST: assert property (test_done && test_low_power |-> ##[1:2] full_start)
        else $error("no full test after low");
    AST_SYNC_MASTER: assert property (sync_start |-> is_master ##1 !sync_start)
        else $error("bad sync pulse");
    AST_LOOP_SPAN: assert property ($fell(carrier_key) |->
        key_len >= 4 * TICK_CYCLES && key_len <= 61 * TICK_CYCLES)
        else $error("bad keying length");
endmodule // checkback_alarm_scheduler_checker

bind checkback_alarm_scheduler checkback_alarm_scheduler_checker #(
    .TICK_CYCLES(TICK_CYCLES)
) u_checker (
    .hclk, .hresetn, .hreadyout, .hresp, .is_master, .test_done, .msg_fail,
    .start_test, .test_low_power, .carrier_key, .sync_start, .retry_req, .comm_error
);

// ==== test/testbench.sv ====
`timescale 1ns/1ps
`include "checkback_defines.vh"
module testbench;
    localparam int TICK = 20;
    logic hclk = 1'h0, hresetn = 1'h0, hsel = 1'h0, hwrite = 1'h0, custom_sel = 1'h1;
    logic is_master = 1'h1, major_event = 1'h0, minor_event = 1'h0, msg_fail = 1'h0;
    logic msg_ok = 1'h0, chan_busy = 1'h0, panel_test = 1'h0, loop_switch = 1'h0;
    logic pass_mode = 1'h1;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [7:0] lat = 8'h1E;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, q;
    logic [73:0] rows [16];
    wire [31:0] hrdata;
    wire [2:0] user_out;
    wire hreadyout, hresp, major_relay, minor_relay, start_test, test_low_power;
    wire carrier_key, sync_start, retry_req, comm_error, test_done, test_pass;
    int error_cnt = 0, comparisons = 0, starts = 0, lows = 0, dones = 0, retries = 0;
    int errs = 0, syncs = 0, keyc = 0, rech = 0, s0, y0, d0, k0;

    // ------------------------------------------
    // design, far side, clock
    // ------------------------------------------
    checkback_alarm_scheduler #(.TICK_CYCLES(TICK)) dut (.hready(hreadyout), .*);
    checkback_partner partner (.*);
    initial
        forever #50 hclk = ~hclk;
    // output pulse counters
    always @(posedge hclk)
    begin
        starts += start_test;
        lows += start_test & test_low_power;
        dones += test_done;
        retries += retry_req;
        errs += comm_error;
        syncs += sync_start;
        keyc += carrier_key;
        rech += user_out[0];
    end

    // ------------------------------------------
    // shared tasks
    // ------------------------------------------
    task chk(input string nm, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task tally_and_finish;
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task wait_ready;
        int k;
        k = 0;
        do
        begin
            @(posedge hclk);
            k++;
        end
        while (hreadyout !== 1'h1 && k < 20);
        if (k == 20)
        begin
            error_cnt++;
            tally_and_finish;
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_ready;
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_ready;
        q = hrdata;
    endtask
    task alarm;
        major_event <= 1'h1;
        minor_event <= 1'h1;
        @(posedge hclk);
        major_event <= 1'h0;
        minor_event <= 1'h0;
    endtask
    task msg(input logic f);
        msg_fail <= f;
        msg_ok <= ~f;
        @(posedge hclk);
        msg_fail <= 1'h0;
        msg_ok <= 1'h0;
        tick(3);
    endtask
    task sched(input logic [31:0] c, t, input int es, ey);
        bus(1'h1, `OFS_CFG, c);
        bus(1'h1, `OFS_TOD, t);
        s0 = starts;
        y0 = syncs;
        tick(100);
        chk("scheduled tests", starts - s0, es);
        chk("sync starts", syncs - y0, ey);
    endtask
    task wait_dones(input int n);
        int k;
        k = 0;
        while (dones - d0 < n && k < 2000)
        begin
            @(posedge hclk);
            k++;
        end
        chk("test answers", dones - d0, n);
        if (k == 2000)
            tally_and_finish;
    endtask

    // ------------------------------------------
    // main sequence
    // ------------------------------------------
    initial
    begin
        rows = '{
            {2'h0, `OFS_CFG, 32'h0, 32'h40},
            {2'h0, `OFS_OUTSEL, 32'h0, 32'h132},
            {2'h0, `OFS_HOURS, 32'h0, 32'h0303_0303},
            {2'h0, `OFS_TIMING, 32'h0, 32'h010F_0504},
            {2'h0, `OFS_RETRY, 32'h0, 32'h3},
            {2'h3, `OFS_RETRY, 32'h14, 32'h14},
            {2'h3, `OFS_RETRY, 32'h15, 32'h14},
            {2'h2, `OFS_RETRY, 32'h5, 32'h14},
            {2'h3, `OFS_TIMING, 32'h010F_0500, 32'h010F_0504},
            {2'h3, `OFS_TIMING, 32'h010F_0304, 32'h010F_0504},
            {2'h3, `OFS_TIMING, 32'h190F_0504, 32'h010F_0504},
            {2'h3, `OFS_OUTSEL, 32'h162, 32'h132},
            {2'h3, `OFS_HOURS, 32'h0318_0303, 32'h0303_0303},
            {2'h3, 8'h40, 32'h5A, 32'h0},
            {2'h3, `OFS_TIMING, 32'h0101_0401, 32'h0101_0401},
            {2'h3, `OFS_RETRY, 32'h2, 32'h2}};
        tick(10);
        hresetn <= 1'h1;
        tick(1);
        chk("reset outputs", {major_relay, minor_relay, user_out, carrier_key}, 6'h3E);
        foreach (rows[i])
        begin
            custom_sel <= rows[i][72];
            if (rows[i][73])
                bus(1'h1, rows[i][71:64], rows[i][63:32]);
            bus(1'h0, rows[i][71:64], 32'h0);
            chk("register", q, rows[i][31:0]);
        end
        // user outputs, mixed polarity
        bus(1'h1, `OFS_CFG, 32'h508);
        bus(1'h1, `OFS_OUTSEL, 32'h432);
        tick(2);
        chk("user idle", user_out, 3'h6);
        s0 = starts;
        k0 = lows;
        d0 = dones;
        bus(1'h1, `OFS_CMD, 32'h1);
        tick(10);
        chk("user testing", user_out, 3'h7);
        wait_dones(2);
        tick(3);
        chk("user passed", user_out, 3'h4);
        chk("starts", starts - s0, 2);
        chk("low starts", lows - k0, 1);
        // relays: momentary then sealed
        bus(1'h1, `OFS_CFG, 32'h005);
        tick(2);
        chk("relays idle", {major_relay, minor_relay}, 2'h1);
        alarm;
        tick(80);
        chk("relays held", {major_relay, minor_relay}, 2'h2);
        tick(50);
        chk("relays released", {major_relay, minor_relay}, 2'h1);
        bus(1'h1, `OFS_CFG, 32'h001);
        alarm;
        tick(140);
        chk("relays sealed", {major_relay, minor_relay}, 2'h2);
        bus(1'h1, `OFS_CMD, 32'h4);
        tick(3);
        chk("relays cleared", {major_relay, minor_relay}, 2'h1);
        // retries with a limit of two
        s0 = retries;
        y0 = errs;
        repeat (3) msg(1'h1);
        msg(1'h1);
        msg(1'h0);
        msg(1'h1);
        msg(1'h1);
        chk("retries", retries - s0, 5);
        chk("comm errors", errs - y0, 1);
        // loopback by command and by switch
        k0 = keyc;
        bus(1'h1, `OFS_CMD, 32'h2);
        tick(130);
        chk("key by command", keyc - k0 >= 80 && keyc - k0 <= 100, 1);
        k0 = keyc;
        loop_switch <= 1'h1;
        tick(130);
        chk("key by switch", keyc - k0 >= 80 && keyc - k0 <= 100, 1);
        loop_switch <= 1'h0;
        // timed slots, busy deferral
        bus(1'h1, `OFS_HOURS, 32'h0705_0505);
        bus(1'h1, `OFS_CFG, 32'h050);
        chan_busy <= 1'h1;
        bus(1'h1, `OFS_TOD, 32'h0004_3B3A);
        s0 = starts;
        tick(80);
        chk("busy deferral", starts - s0, 0);
        chan_busy <= 1'h0;
        tick(80);
        chk("timed start", starts - s0, 1);
        sched(32'h040, 32'h0005_3B3A, 1, 0);
        sched(32'h080, 32'h0000_1D3A, 0, 0);
        sched(32'h080, 32'h0000_3B3A, 0, 0);
        sched(32'h0C0, 32'h0000_1D3A, 0, 1);
        is_master <= 1'h0;
        sched(32'h0C0, 32'h0000_1D3A, 0, 0);
        // recovery, window, three passes
        is_master <= 1'h1;
        lat <= 8'h00;
        pass_mode <= 1'h0;
        bus(1'h1, `OFS_OUTSEL, 32'h510);
        bus(1'h1, `OFS_CFG, 32'h760);
        tick(2);
        chk("recovery idle", user_out, 3'h0);
        panel_test <= 1'h1;
        tick(1);
        panel_test <= 1'h0;
        tick(20);
        chk("in recovery", user_out, 3'h4);
        s0 = starts;
        tick(2640);
        chk("expedited tests", starts - s0 >= 2, 1);
        chk("window open", user_out, 3'h4);
        tick(73200);
        chk("delayed alarm", user_out, 3'h6);
        pass_mode <= 1'h1;
        k0 = rech;
        tick(4800);
        chk("recovered", user_out, 3'h0);
        chk("success pulse", rech - k0 >= 20 && rech - k0 <= 40, 1);
        tally_and_finish;
    end
endmodule // testbench
